// *** hw/pwc_consts.svh ***
`ifndef PWC_CONSTS_SVH
`define PWC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PWC_ADDR_W        8
`define PWC_OFF_MODE      8'h00
`define PWC_OFF_ENABLE    8'h04
`define PWC_OFF_DISABLE   8'h08
`define PWC_OFF_STATUS    8'h0C
`define PWC_OFF_DUTY      8'h10
`define PWC_OFF_PERIOD    8'h14
`define PWC_OFF_COUNTER   8'h18
`define PWC_OFF_UPDATE    8'h1C

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define PWC_VAL_W         16
`define PWC_SEL_W         4
`define PWC_MODE_SEL_LSB  0
`define PWC_MODE_CENTER   8
`define PWC_MODE_POL      9
`define PWC_MODE_UPD_PRD  10
`define PWC_CMD_BIT       0
`define PWC_STAT_EN_BIT   0
`define PWC_SEL_MAX       4'hA
`define PWC_DIV_W         11

// ----------------------------------------------------------------
// Reset and restart values
// ----------------------------------------------------------------
`define PWC_RST_VAL       16'h0000
`define PWC_RST_SEL       4'h0
`define PWC_CNT_START     16'h0000
`define PWC_CNT_RESTART   16'h0001

`endif

// *** hw/pwc_pkg.sv ***
`include "pwc_consts.svh"

package pwc_pkg;

    typedef logic [`PWC_VAL_W-1:0]  pwc_val_t;
    typedef logic [`PWC_ADDR_W-1:0] pwc_addr_t;

    // Channel configuration held in the mode register
    typedef struct packed {
        logic                  upd_period;
        logic                  polarity;
        logic                  center;
        logic [`PWC_SEL_W-1:0] clk_sel;
    } pwc_cfg_s;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        pwc_addr_t   addr;
        logic [31:0] wdata;
    } pwc_req_s;

    // Channel activity
    typedef enum logic [2:0] {
        PWC_IDLE  = 3'b001,
        PWC_FIRST = 3'b010,
        PWC_RUN   = 3'b100
    } pwc_state_e;

endpackage : pwc_pkg

// *** hw/pwc_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwc_consts.svh"

module pwc_prescaler (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clr,
    input  wire logic [`PWC_SEL_W-1:0] sel,
    output var  logic                  tick
);
    import pwc_pkg::*;

    logic [`PWC_DIV_W-1:0] div_q;
    logic [`PWC_DIV_W-1:0] mask;

    // ------------------------------------------------------------
    // Divider: tick once every 2^sel master clocks
    // ------------------------------------------------------------
    // Selections above 10 divide by 2^11 master clocks, twice the largest divider
    always_comb begin
        if (sel > `PWC_SEL_MAX) begin
            mask = {`PWC_DIV_W{1'b1}};
        end else begin
            mask = `PWC_DIV_W'((1 << sel) - 1);
        end
    end

    // Cleared on enable so the first selected-clock period is whole
    always_ff @(posedge clk) begin
        if (sys_rst || clr) begin
            div_q <= '0;
            tick  <= 1'b0;
        end else begin
            div_q <= div_q + `PWC_DIV_W'(1);
            tick  <= ((div_q & mask) == mask);
        end
    end

endmodule : pwc_prescaler
`default_nettype wire

// *** hw/pwc_channel.sv ***
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_consts.svh"

module pwc_channel (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire pwc_pkg::pwc_addr_t reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [31:0]       reg_rdata,
    output var  logic              pwm_out
);
    import pwc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pwc_req_s   req;
    pwc_cfg_s   cfg_q;
    pwc_state_e state_q;
    pwc_val_t   duty_q;
    pwc_val_t   period_q;
    pwc_val_t   counter_q;
    pwc_val_t   upd_val_q;
    logic       upd_pend_q;
    logic       upd_prd_q;
    logic       down_q;
    logic       enabled_flag_q;
    logic       tick;
    logic       wr_mode;
    logic       wr_enable;
    logic       wr_disable;
    logic       wr_duty;
    logic       wr_period;
    logic       wr_update;
    logic       period_end;
    logic       early;
    logic       apply_now;
    logic       apply_end;
    logic       upd_ok;

    // Decode a write strobe against one register offset
    function automatic logic hit(input pwc_req_s r, input pwc_addr_t off);
        hit = r.wr && (r.addr == off);
    endfunction : hit

    // Counter value that must not defer an update write
    function automatic logic in_early_window(input pwc_val_t c);
        in_early_window = (c == `PWC_CNT_START) || (c == `PWC_CNT_RESTART);
    endfunction : in_early_window

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;

    assign wr_mode    = hit(req, `PWC_OFF_MODE);
    assign wr_enable  = hit(req, `PWC_OFF_ENABLE) && req.wdata[`PWC_CMD_BIT];
    assign wr_disable = hit(req, `PWC_OFF_DISABLE) && req.wdata[`PWC_CMD_BIT];
    assign wr_duty    = hit(req, `PWC_OFF_DUTY);
    assign wr_period  = hit(req, `PWC_OFF_PERIOD);
    assign wr_update  = hit(req, `PWC_OFF_UPDATE);

    // ------------------------------------------------------------
    // Selected clock
    // ------------------------------------------------------------
    pwc_prescaler u_prescaler (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clr     (wr_enable),
        .sel     (cfg_q.clk_sel),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // Mode may change while running; the new polarity shows at once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_q <= '{upd_period: 1'b0, polarity: 1'b0, center: 1'b0,
                       clk_sel: `PWC_RST_SEL};
        end else if (wr_mode) begin
            cfg_q.clk_sel    <= req.wdata[`PWC_MODE_SEL_LSB +: `PWC_SEL_W];
            cfg_q.center     <= req.wdata[`PWC_MODE_CENTER];
            cfg_q.polarity   <= req.wdata[`PWC_MODE_POL];
            cfg_q.upd_period <= req.wdata[`PWC_MODE_UPD_PRD];
        end
    end

    // ------------------------------------------------------------
    // Channel activity
    // ------------------------------------------------------------
    // FIRST lasts until one selected-clock period has passed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= PWC_IDLE;
        end else if (wr_enable) begin
            state_q <= PWC_FIRST;
        end else begin
            unique case (state_q)
                PWC_IDLE: begin
                    state_q <= PWC_IDLE;
                end
                PWC_FIRST: begin
                    if (wr_disable) begin
                        state_q <= PWC_IDLE;
                    end else if (tick) begin
                        state_q <= PWC_RUN;
                    end
                end
                PWC_RUN: begin
                    if (wr_disable) begin
                        state_q <= PWC_IDLE;
                    end
                end
            endcase
        end
    end

    // Enabled flag: an early disable leaves it set, a later one clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enabled_flag_q <= 1'b0;
        end else if (wr_enable) begin
            enabled_flag_q <= 1'b1;
        end else if (wr_disable && (state_q == PWC_RUN)) begin
            enabled_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    // End of period: top of a left-aligned ramp, bottom of a centre one
    always_comb begin
        if (cfg_q.center) begin
            period_end = tick && down_q && (counter_q <= `PWC_CNT_RESTART);
        end else begin
            period_end = tick && (counter_q >= period_q);
        end
    end

    // Only counts while the line is active; a period of 0 freezes it
    always_ff @(posedge clk) begin
        if (sys_rst || (state_q == PWC_IDLE) || wr_enable) begin
            counter_q <= `PWC_CNT_START;
            down_q    <= 1'b0;
        end else if (tick && (period_q != `PWC_RST_VAL)) begin
            if (cfg_q.center) begin
                if (!down_q && (counter_q >= period_q)) begin
                    down_q    <= 1'b1;
                    counter_q <= counter_q - `PWC_VAL_W'(1);
                end else if (down_q && (counter_q == `PWC_CNT_START)) begin
                    down_q    <= 1'b0;
                    counter_q <= counter_q + `PWC_VAL_W'(1);
                end else if (down_q) begin
                    counter_q <= counter_q - `PWC_VAL_W'(1);
                end else begin
                    counter_q <= counter_q + `PWC_VAL_W'(1);
                end
            end else if (period_end) begin
                counter_q <= `PWC_CNT_RESTART;
            end else begin
                counter_q <= counter_q + `PWC_VAL_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Update path
    // ------------------------------------------------------------
    // Period updates are dropped entirely while the active period is 0
    assign upd_ok    = !cfg_q.upd_period || (period_q != `PWC_RST_VAL);
    assign early     = in_early_window(counter_q);
    assign apply_now = wr_update && early && upd_ok;
    assign apply_end = upd_pend_q && period_end && !wr_update;

    // Pending update; a new write in the same cycle as the period end
    // wins, so its value is never lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upd_pend_q <= 1'b0;
            upd_val_q  <= `PWC_RST_VAL;
            upd_prd_q  <= 1'b0;
        end else if (wr_update && !early && upd_ok) begin
            upd_pend_q <= 1'b1;
            upd_val_q  <= req.wdata[`PWC_VAL_W-1:0];
            upd_prd_q  <= cfg_q.upd_period;
        end else if (apply_now || apply_end) begin
            upd_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Active duty and period
    // ------------------------------------------------------------
    // Direct writes go straight to the active values
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            duty_q <= `PWC_RST_VAL;
        end else if (wr_duty) begin
            duty_q <= req.wdata[`PWC_VAL_W-1:0];
        end else if (apply_now && !cfg_q.upd_period) begin
            duty_q <= req.wdata[`PWC_VAL_W-1:0];
        end else if (apply_end && !upd_prd_q) begin
            duty_q <= upd_val_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_q <= `PWC_RST_VAL;
        end else if (wr_period) begin
            period_q <= req.wdata[`PWC_VAL_W-1:0];
        end else if (apply_now && cfg_q.upd_period) begin
            period_q <= req.wdata[`PWC_VAL_W-1:0];
        end else if (apply_end && upd_prd_q && (period_q != `PWC_RST_VAL)) begin
            period_q <= upd_val_q;
        end
    end

    // ------------------------------------------------------------
    // Waveform
    // ------------------------------------------------------------
    // Off whenever the line is internally disabled, even if the flag
    // still reads 1 after an early disable
    always_ff @(posedge clk) begin
        if (sys_rst || (state_q == PWC_IDLE)) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (counter_q < duty_q) ^ cfg_q.polarity;
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the read strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            unique case (req.addr)
                `PWC_OFF_MODE: begin
                    reg_rdata <= 32'({cfg_q.upd_period, cfg_q.polarity, cfg_q.center,
                                      4'h0, cfg_q.clk_sel});
                end
                `PWC_OFF_STATUS: begin
                    reg_rdata <= 32'(enabled_flag_q);
                end
                `PWC_OFF_DUTY: begin
                    reg_rdata <= 32'(duty_q);
                end
                `PWC_OFF_PERIOD: begin
                    reg_rdata <= 32'(period_q);
                end
                `PWC_OFF_COUNTER: begin
                    reg_rdata <= 32'(counter_q);
                end
                `PWC_OFF_UPDATE: begin
                    reg_rdata <= 32'(upd_val_q);
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : pwc_channel
`default_nettype wire

// *** bench/pwc_channel_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwc_consts.svh"

module pwc_monitor (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire pwc_pkg::pwc_addr_t reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    input wire logic               pwm_out
);
    import pwc_pkg::*;
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------------------------------
    // Decoded accesses
    // ----------------------------------------------------------------
    logic en_wr;
    logic dis_wr;
    logic rd_st;
    logic duty_wr;
    assign en_wr   = reg_wr && reg_addr == `PWC_OFF_ENABLE && reg_wdata[`PWC_CMD_BIT];
    assign dis_wr  = reg_wr && reg_addr == `PWC_OFF_DISABLE && reg_wdata[`PWC_CMD_BIT];
    assign rd_st   = reg_rd && reg_addr == `PWC_OFF_STATUS;
    assign duty_wr = reg_wr && reg_addr == `PWC_OFF_DUTY;

    // Remembers a start since reset; the line must stay quiet before one
    logic en_seen_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_seen_q <= 1'b0;
        end else if (en_wr) begin
            en_seen_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    AST_RESET_QUIET: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 32'h0 && !pwm_out)
        else $error("outputs not cleared by reset");
    AST_FLAG_SET: assert property (en_wr ##2 rd_st |=> reg_rdata[`PWC_STAT_EN_BIT])
        else $error("enabled flag not set after start");
    AST_FIRST_ZERO: assert property (
        en_wr ##2 (reg_rd && reg_addr == `PWC_OFF_COUNTER) |=> reg_rdata == 32'h0)
        else $error("counter not zero at the first period start");
    AST_EARLY_FLAG: assert property (en_wr ##2 dis_wr ##2 rd_st |=> reg_rdata[0])
        else $error("enabled flag cleared by an early stop");
    AST_STOP_QUIET: assert property (dis_wr |-> ##2 (!pwm_out) [*2])
        else $error("line still active after stop");
    AST_DUTY_BACK: assert property (duty_wr ##2 (reg_rd && reg_addr == `PWC_OFF_DUTY)
        |=> reg_rdata == {16'h0000, $past(reg_wdata[15:0], 3)})
        else $error("duty read back differs from written value");
    AST_NO_START: assert property (!en_seen_q |-> !pwm_out)
        else $error("line active before any start");

    COV_EARLY: cover property (en_wr ##2 dis_wr);
    COV_PULSE: cover property ($rose(pwm_out));
    COV_FLAG: cover property (en_wr ##2 rd_st);
endmodule : pwc_monitor

bind pwc_channel pwc_monitor u_pwc_monitor (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .pwm_out   (pwm_out)
);
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwc_consts.svh"

module testbench;
    import pwc_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        reg_wr;
    logic        reg_rd;
    logic        pwm_out;
    pwc_addr_t   reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic [31:0] zs;
    logic [31:0] mn;
    logic [31:0] mx;
    int          errors;
    int          checked;
    pwc_addr_t   ta [2] = '{`PWC_OFF_DUTY, `PWC_OFF_PERIOD};
    logic [31:0] tv [2] = '{32'h7, 32'hA};
    logic [31:0] tn [2] = '{32'h3, 32'hC};

    pwc_channel u_pwc_channel (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .pwm_out   (pwm_out)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Register port tasks: one strobe cycle, then a free cycle
    // ----------------------------------------------------------------
    task automatic wr(input pwc_addr_t a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input pwc_addr_t a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input pwc_addr_t a, input logic [31:0] exp);
        rd(a, rv);
        chk(rv, exp);
    endtask : rchk

    // Polls the counter so that an update lands outside the early window
    task automatic poll(input logic [31:0] v);
        int n;
        n = 0;
        rd(`PWC_OFF_COUNTER, rv);
        while (rv !== v && n < 300) begin
            rd(`PWC_OFF_COUNTER, rv);
            n++;
        end
        chk(rv, v);
    endtask : poll

    task automatic hicount(input int n, output logic [31:0] hi);
        hi = 32'h0;
        repeat (n) begin
            @(posedge clk);
            #1;
            hi = hi + {31'h0, pwm_out};
        end
    endtask : hicount

    function automatic logic [31:0] md(input logic [3:0] s, input logic p, input logic t);
        md = 32'h0;
        md[3:0] = s;
        md[`PWC_MODE_POL] = p;
        md[`PWC_MODE_UPD_PRD] = t;
    endfunction : md

    task automatic tdone(input string name);
        $display("Test %s finished, mismatches so far %0d", name, errors);
    endtask : tdone

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // Cuts a hang short; the whole sequence needs well under 2000 cycles
    initial begin
        #(40 * 20000);
        errors++;
        $display("ERROR t=%0t watchdog expired got=%h exp=%h", $time, 32'h0, 32'h1);
        conclude();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        errors    = 0;
        checked   = 0;
        sys_rst   = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, an unmapped place and read-only places
        for (int i = 0; i <= 8; i++) rchk(8'(i * 4), 32'h0);
        wr(`PWC_OFF_STATUS, 32'hFFFF);
        wr(`PWC_OFF_COUNTER, 32'hFFFF);
        wr(8'h20, 32'hFFFF);
        rchk(`PWC_OFF_STATUS, 32'h0);
        rchk(`PWC_OFF_COUNTER, 32'h0);
        wr(`PWC_OFF_DUTY, 32'hABCD1234);
        rchk(`PWC_OFF_DUTY, 32'h1234);
        tdone("registers");
        // Left-aligned run, period 5 duty 2, fastest clock
        wr(`PWC_OFF_MODE, md(4'h0, 1'b0, 1'b0));
        wr(`PWC_OFF_PERIOD, 32'h5);
        wr(`PWC_OFF_DUTY, 32'h2);
        wr(`PWC_OFF_ENABLE, 32'h1);
        rchk(`PWC_OFF_COUNTER, 32'h0);
        zs = 32'h0;
        mn = 32'hFF;
        mx = 32'h0;
        repeat (10) begin
            rd(`PWC_OFF_COUNTER, rv);
            if (rv === 32'h0) zs = 32'h1;
            if (rv < mn) mn = rv;
            if (rv > mx) mx = rv;
        end
        chk(zs, 32'h0);
        chk(mn, 32'h1);
        chk(mx, 32'h5);
        hicount(50, rv);
        chk(rv, 32'hA);
        wr(`PWC_OFF_MODE, md(4'h0, 1'b1, 1'b0));
        hicount(50, rv);
        chk(rv, 32'h28);
        // Centre-aligned triangle 0..5..0: duty 2 leaves three high cycles in ten
        wr(`PWC_OFF_MODE, 32'h1 << `PWC_MODE_CENTER);
        hicount(50, rv);
        chk(rv, 32'hF);
        tdone("waveform");
        // Early-window update, then deferred updates of duty and period
        wr(`PWC_OFF_DISABLE, 32'h1);
        wr(`PWC_OFF_MODE, md(4'h3, 1'b0, 1'b0));
        wr(`PWC_OFF_PERIOD, 32'hA);
        wr(`PWC_OFF_DUTY, 32'h2);
        wr(`PWC_OFF_ENABLE, 32'h1);
        wr(`PWC_OFF_UPDATE, 32'h7);
        rchk(`PWC_OFF_DUTY, 32'h7);
        for (int t = 0; t < 2; t++) begin
            wr(`PWC_OFF_MODE, md(4'h3, 1'b0, t[0]));
            poll(32'h4);
            wr(`PWC_OFF_UPDATE, tn[t]);
            rchk(ta[t], tv[t]);
            repeat (100) @(posedge clk);
            rchk(ta[t], tn[t]);
        end
        tdone("update");
        // Period zero: counter frozen and period updates dropped
        wr(`PWC_OFF_DISABLE, 32'h1);
        wr(`PWC_OFF_PERIOD, 32'h0);
        wr(`PWC_OFF_ENABLE, 32'h1);
        repeat (20) @(posedge clk);
        rchk(`PWC_OFF_COUNTER, 32'h0);
        wr(`PWC_OFF_UPDATE, 32'h6);
        rchk(`PWC_OFF_PERIOD, 32'h0);
        repeat (30) @(posedge clk);
        rchk(`PWC_OFF_PERIOD, 32'h0);
        tdone("period zero");
        // Stop right after start, then a stop after a full selected-clock period
        wr(`PWC_OFF_DISABLE, 32'h1);
        wr(`PWC_OFF_PERIOD, 32'hA);
        // Counter sits at 0 while stopped, so a period update lands at once
        wr(`PWC_OFF_UPDATE, 32'h9);
        rchk(`PWC_OFF_PERIOD, 32'h9);
        wr(`PWC_OFF_DUTY, 32'h5);
        wr(`PWC_OFF_ENABLE, 32'h1);
        wr(`PWC_OFF_DISABLE, 32'h1);
        rchk(`PWC_OFF_STATUS, 32'h1);
        hicount(20, rv);
        chk(rv, 32'h0);
        wr(`PWC_OFF_ENABLE, 32'h1);
        rchk(`PWC_OFF_STATUS, 32'h1);
        repeat (20) @(posedge clk);
        wr(`PWC_OFF_DISABLE, 32'h1);
        rchk(`PWC_OFF_STATUS, 32'h0);
        tdone("stop");
        conclude();
    end
endmodule : testbench
`default_nettype wire
